// >>> hdl/edp_pkg.sv
package edp_pkg;

	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int ACC_W  = 34;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [15:0] IDX_ROT_DIR     = 16'h2000;
	localparam logic [15:0] IDX_ORIGIN_SEL  = 16'h2081;
	localparam logic [15:0] IDX_PULSE_CNT   = 16'h2212;
	localparam logic [15:0] IDX_LIN_RES     = 16'h2281;
	localparam logic [15:0] IDX_CTRL        = 16'h2f00;
	localparam logic [15:0] IDX_ENC_RES     = 16'h2f01;
	localparam logic [15:0] IDX_PITCH_EDGES = 16'h2f02;
	localparam logic [15:0] IDX_STATUS      = 16'h2f03;
	localparam logic [15:0] IDX_POSITION    = 16'h2f04;

	localparam logic [ADDR_W-1:0] A_ROT_DIR     = {IDX_ROT_DIR, 2'b00};
	localparam logic [ADDR_W-1:0] A_ORIGIN_SEL  = {IDX_ORIGIN_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] A_PULSE_CNT   = {IDX_PULSE_CNT, 2'b00};
	localparam logic [ADDR_W-1:0] A_LIN_RES     = {IDX_LIN_RES, 2'b00};
	localparam logic [ADDR_W-1:0] A_CTRL        = {IDX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] A_ENC_RES     = {IDX_ENC_RES, 2'b00};
	localparam logic [ADDR_W-1:0] A_PITCH_EDGES = {IDX_PITCH_EDGES, 2'b00};
	localparam logic [ADDR_W-1:0] A_STATUS      = {IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] A_POSITION    = {IDX_POSITION, 2'b00};

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_REVERSE   = 0;
	localparam int BIT_BOTH_DIR  = 0;
	localparam int BIT_LINEAR    = 0;
	localparam int BIT_RESTART   = 1;
	localparam int ST_ARMED      = 0;
	localparam int ST_LINEAR     = 1;
	localparam int ST_BOTH_DIR   = 2;
	localparam int ST_REVERSE    = 3;
	localparam int ST_ORIGIN     = 4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0]       RST_ROT_DIR     = 16'h0000;
	localparam logic [15:0]       RST_ORIGIN_SEL  = 16'h0000;
	localparam logic [DATA_W-1:0] RST_PULSE_CNT   = 32'h0000_0800;
	localparam logic [DATA_W-1:0] RST_LIN_RES     = 32'h0000_0014;
	localparam logic [DATA_W-1:0] RST_ENC_RES     = 32'h0100_0000;
	localparam logic [DATA_W-1:0] RST_PITCH_EDGES = 32'h0000_0100;

	// ****************************************************************
	// Origin pulse: one A pulse spans this many output edges
	// ****************************************************************
	localparam logic [1:0] ORIGIN_EDGES = 2'h2;

endpackage

// >>> hdl/edp_quad_gen.sv
`timescale 1ns/1ps
`default_nettype none

module edp_quad_gen
	import edp_pkg::*;
(
	input  wire logic pclk,      // Clock
	input  wire logic presetn,   // Async reset, active low
	input  wire logic ce,        // Clock enable
	input  wire logic clear,     // Return to phase state 0
	input  wire logic step,      // One output edge
	input  wire logic fwd,       // Step direction, 1 = forward
	output logic      a_out,     // Phase A
	output logic      a_out_n,   // Phase A complement
	output logic      b_out,     // Phase B
	output logic      b_out_n    // Phase B complement
);

	// ****************************************************************
	// Gray sequence 00,01,11,10: A leads B going forward
	// ****************************************************************
	typedef enum logic [1:0] {
		Q0 = 2'b00,
		Q1 = 2'b01,
		Q2 = 2'b11,
		Q3 = 2'b10
	} edp_quad_t;

	edp_quad_t state_r;
	edp_quad_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (step) begin
			case (state_r)
				Q0:      state_nxt = fwd ? Q1 : Q3;
				Q1:      state_nxt = fwd ? Q2 : Q0;
				Q2:      state_nxt = fwd ? Q3 : Q1;
				Q3:      state_nxt = fwd ? Q0 : Q2;
				default: state_nxt = Q0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= Q0;
		end else if (ce) begin
			state_r <= clear ? Q0 : state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_out   <= 1'b0;
			a_out_n <= 1'b1;
			b_out   <= 1'b0;
			b_out_n <= 1'b1;
		end else if (ce) begin
			a_out   <= clear ? 1'b0 : state_nxt[0];
			a_out_n <= clear ? 1'b1 : ~state_nxt[0];
			b_out   <= clear ? 1'b0 : state_nxt[1];
			b_out_n <= clear ? 1'b1 : ~state_nxt[1];
		end
	end

endmodule

`default_nettype wire

// >>> hdl/edp_pulse_out.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module edp_pulse_out
	import edp_pkg::*;
(
	input  wire logic              pclk,          // Clock, 10 MHz
	input  wire logic              presetn,       // Async reset, active low
	input  wire logic              ce,            // Clock enable, freezes all state
	input  wire logic              psel,          // APB select
	input  wire logic              penable,       // APB enable
	input  wire logic              pwrite,        // APB direction
	input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
	input  wire logic [DATA_W-1:0] pwdata,        // APB write data
	output logic      [DATA_W-1:0] prdata,        // APB read data
	output logic                   pready,        // APB ready
	output logic                   pslverr,       // APB error
	input  wire logic              enc_step,      // One encoder count
	input  wire logic              enc_up,        // Encoder counts up
	input  wire logic              enc_origin,    // Encoder reference mark seen
	output logic                   quad_a_out,    // Phase A
	output logic                   quad_a_out_n,  // Phase A complement
	output logic                   quad_b_out,    // Phase B
	output logic                   quad_b_out_n,  // Phase B complement
	output logic                   origin_out,    // Origin pulse
	output logic                   origin_out_n   // Origin pulse complement
);

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [15:0]       rotation_direction_select_r;
	logic [15:0]       origin_pulse_direction_select_r;
	logic [DATA_W-1:0] rotary_output_pulse_count_r;
	logic [DATA_W-1:0] linear_output_resolution_r;
	logic              linear_motor_r;
	logic [DATA_W-1:0] enc_counts_per_rev_r;
	logic [DATA_W-1:0] pitch_edges_r;

	// Settings in force since the last restart
	logic              act_reverse_r;
	logic              act_both_dir_r;
	logic              act_linear_r;
	logic [ACC_W-1:0]  act_num_r;
	logic [ACC_W-1:0]  act_den_r;
	logic              loaded_r;

	logic              armed_r;
	logic [ACC_W-1:0]  acc_r;
	logic [DATA_W-1:0] position_r;
	logic [1:0]        origin_left_r;
	logic              origin_r;
	logic              origin_n_r;

	logic              wr_en;
	logic              rd_en;
	logic              addr_hit;
	logic              restart;
	logic              mov_fwd;
	logic              origin_dir_ok;
	logic              origin_take;
	logic [ACC_W-1:0]  acc_sum;
	logic              out_step;
	logic [ACC_W-1:0]  num_nxt;
	logic [ACC_W-1:0]  den_nxt;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	always_comb begin
		case (paddr)
			A_ROT_DIR, A_ORIGIN_SEL, A_PULSE_CNT, A_LIN_RES, A_CTRL,
			A_ENC_RES, A_PITCH_EDGES, A_STATUS, A_POSITION: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// A write of the restart bit or the first cycle after reset reloads settings
	assign restart = !loaded_r || (wr_en && paddr == A_CTRL && pwdata[BIT_RESTART]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rotation_direction_select_r     <= RST_ROT_DIR;
			origin_pulse_direction_select_r <= RST_ORIGIN_SEL;
			rotary_output_pulse_count_r     <= RST_PULSE_CNT;
			linear_output_resolution_r      <= RST_LIN_RES;
			linear_motor_r                  <= 1'b0;
			enc_counts_per_rev_r            <= RST_ENC_RES;
			pitch_edges_r                   <= RST_PITCH_EDGES;
		end else if (ce && wr_en) begin
			case (paddr)
				A_ROT_DIR:     rotation_direction_select_r     <= pwdata[15:0];
				A_ORIGIN_SEL:  origin_pulse_direction_select_r <= pwdata[15:0];
				A_PULSE_CNT:   rotary_output_pulse_count_r     <= pwdata;
				A_LIN_RES:     linear_output_resolution_r      <= pwdata;
				A_CTRL:        linear_motor_r                  <= pwdata[BIT_LINEAR];
				A_ENC_RES:     enc_counts_per_rev_r            <= pwdata;
				A_PITCH_EDGES: pitch_edges_r                   <= pwdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		prdata = '0;
		if (rd_en) begin
			case (paddr)
				A_ROT_DIR:     prdata = {16'h0000, rotation_direction_select_r};
				A_ORIGIN_SEL:  prdata = {16'h0000, origin_pulse_direction_select_r};
				A_PULSE_CNT:   prdata = rotary_output_pulse_count_r;
				A_LIN_RES:     prdata = linear_output_resolution_r;
				A_CTRL:        prdata = {31'h0000_0000, linear_motor_r};
				A_ENC_RES:     prdata = enc_counts_per_rev_r;
				A_PITCH_EDGES: prdata = pitch_edges_r;
				A_STATUS: begin
					prdata[ST_ARMED]    = armed_r;
					prdata[ST_LINEAR]   = act_linear_r;
					prdata[ST_BOTH_DIR] = act_both_dir_r;
					prdata[ST_REVERSE]  = act_reverse_r;
					prdata[ST_ORIGIN]   = origin_r;
				end
				A_POSITION:    prdata = position_r;
				default:       prdata = '0;
			endcase
		end
	end

	// ****************************************************************
	// Division ratio taken at restart
	// ****************************************************************
	// Rotary: 4 output edges per pulse against encoder counts per revolution
	// Linear: output edges per pitch against feedback edges per pitch
	always_comb begin
		if (linear_motor_r) begin
			num_nxt = {2'b00, linear_output_resolution_r};
			den_nxt = {2'b00, pitch_edges_r};
		end else begin
			num_nxt = {rotary_output_pulse_count_r, 2'b00};
			den_nxt = {2'b00, enc_counts_per_rev_r};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r       <= 1'b0;
			act_reverse_r  <= 1'b0;
			act_both_dir_r <= 1'b0;
			act_linear_r   <= 1'b0;
			act_num_r      <= '0;
			act_den_r      <= '0;
		end else if (ce && restart) begin
			loaded_r       <= 1'b1;
			act_reverse_r  <= rotation_direction_select_r[BIT_REVERSE];
			act_both_dir_r <= origin_pulse_direction_select_r[BIT_BOTH_DIR];
			act_linear_r   <= linear_motor_r;
			act_num_r      <= num_nxt;
			act_den_r      <= den_nxt;
		end
	end

	// ****************************************************************
	// Rate divider: one output edge each time the accumulator wraps
	// ****************************************************************
	assign acc_sum  = acc_r + act_num_r;
	assign out_step = loaded_r && enc_step && (acc_sum >= act_den_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= '0;
		end else if (ce) begin
			if (restart) begin
				acc_r <= '0;
			end else if (out_step) begin
				acc_r <= acc_sum - act_den_r;
			end else if (loaded_r && enc_step) begin
				acc_r <= acc_sum;
			end
		end
	end

	// Forward movement in the selected sense; output form stays the same
	assign mov_fwd = enc_up ^ act_reverse_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position_r <= '0;
		end else if (ce) begin
			if (restart) begin
				position_r <= '0;
			end else if (out_step) begin
				position_r <= mov_fwd ? position_r + 32'h0000_0001 : position_r - 32'h0000_0001;
			end
		end
	end

	edp_quad_gen u_quad (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.clear   (restart),
		.step    (out_step),
		.fwd     (mov_fwd),
		.a_out   (quad_a_out),
		.a_out_n (quad_a_out_n),
		.b_out   (quad_b_out),
		.b_out_n (quad_b_out_n)
	);

	// ****************************************************************
	// Origin gating and arming
	// ****************************************************************
	// Forward-only mode: linear uses the encoder count sense until armed, rotary the movement
	always_comb begin
		if (act_both_dir_r) begin
			origin_dir_ok = armed_r || mov_fwd;
		end else if (act_linear_r) begin
			origin_dir_ok = armed_r || enc_up;
		end else begin
			origin_dir_ok = mov_fwd;
		end
	end

	// A reference mark is taken only when origin_dir_ok allows it and no restart is pending
	assign origin_take = loaded_r && !restart && enc_origin && origin_dir_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				armed_r <= 1'b0;
			end else if (origin_take) begin
				armed_r <= 1'b1;
			end
		end
	end

	// Pulse stays high for two output edges, the width of one A pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			origin_left_r <= 2'h0;
			origin_r      <= 1'b0;
			origin_n_r    <= 1'b1;
		end else if (ce) begin
			if (restart) begin
				origin_left_r <= 2'h0;
				origin_r      <= 1'b0;
				origin_n_r    <= 1'b1;
			end else if (origin_take) begin
				origin_left_r <= ORIGIN_EDGES;
				origin_r      <= 1'b1;
				origin_n_r    <= 1'b0;
			end else if (out_step && origin_left_r != 2'h0) begin
				origin_left_r <= origin_left_r - 2'h1;
				origin_r      <= (origin_left_r != 2'h1);
				origin_n_r    <= (origin_left_r == 2'h1);
			end
		end
	end

	assign origin_out   = origin_r;
	assign origin_out_n = origin_n_r;

endmodule

`default_nettype wire

// >>> sim/edp_pulse_out_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module edp_pulse_out_asserts
	import edp_pkg::*;
(
	input wire logic              pclk,         // Clock
	input wire logic              presetn,      // Reset
	input wire logic              ce,           // Enable
	input wire logic              psel,         // Select
	input wire logic              penable,      // Access
	input wire logic              pwrite,       // Write
	input wire logic [ADDR_W-1:0] paddr,        // Address
	input wire logic              pready,       // Ready
	input wire logic              pslverr,      // Error
	input wire logic              enc_step,     // Count
	input wire logic              enc_origin,   // Mark
	input wire logic              quad_a_out,   // A
	input wire logic              quad_a_out_n, // A inverse
	input wire logic              quad_b_out,   // B
	input wire logic              quad_b_out_n, // B inverse
	input wire logic              origin_out,   // Origin
	input wire logic              origin_out_n  // Origin inverse
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire bus_wr = psel && penable && pwrite;

	property p_a_compl; quad_a_out_n == !quad_a_out; endproperty
	a_a_compl: assert property (p_a_compl) else $error("phase A inverse wrong");
	property p_b_compl; quad_b_out_n != quad_b_out; endproperty
	a_b_compl: assert property (p_b_compl) else $error("phase B inverse wrong");
	property p_c_compl; origin_out_n ^ origin_out; endproperty
	a_c_compl: assert property (p_c_compl) else $error("origin inverse wrong");
	property p_one_phase;
		!$past(bus_wr) |-> !($changed(quad_a_out) && $changed(quad_b_out));
	endproperty
	a_one_phase: assert property (p_one_phase) else $error("A and B moved together");
	property p_step_cause;
		$changed(quad_a_out) || $changed(quad_b_out) |-> $past(enc_step && ce) || $past(bus_wr);
	endproperty
	a_step_cause: assert property (p_step_cause) else $error("phase moved without a count");
	property p_origin_cause; $rose(origin_out) |-> $past(enc_origin && ce); endproperty
	a_origin_cause: assert property (p_origin_cause) else $error("origin without mark");
	property p_origin_hold;
		$fell(origin_out) |-> $past(bus_wr) || $changed(quad_a_out) || $changed(quad_b_out)
			|| ($past(quad_a_out) != $past(quad_a_out, 2)) || ($past(quad_b_out) != $past(quad_b_out, 2));
	endproperty
	a_origin_hold: assert property (p_origin_hold) else $error("origin fell while stopped");
	property p_freeze;
		!ce |=> $stable(quad_a_out) && $stable(quad_b_out) && $stable(origin_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
	property p_reg_ok; psel && penable && paddr == A_ORIGIN_SEL |-> pready && !pslverr; endproperty
	a_reg_ok: assert property (p_reg_ok) else $error("origin select access refused");

	c_origin: cover property ($rose(origin_out));
	c_slverr: cover property (pslverr);
	c_freeze: cover property (!ce && enc_step);
endmodule

bind edp_pulse_out edp_pulse_out_asserts chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
	.pready, .pslverr, .enc_step, .enc_origin, .quad_a_out, .quad_a_out_n, .quad_b_out, .quad_b_out_n,
	.origin_out, .origin_out_n);

`default_nettype wire

// >>> sim/edp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module edp_host_model (
	input  wire logic          pclk,    // Clock
	input  wire logic          presetn, // Reset
	input  wire logic          qa,      // Phase A
	input  wire logic          qb,      // Phase B
	input  wire logic          org,     // Origin
	output logic signed [31:0] pos,     // Edge count
	output logic        [7:0]  n_org    // Origins seen
);
	// ****************
	// Quadrature counter
	// ****************
	logic [1:0] ab_r;
	logic       org_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ab_r <= 2'h0;
			org_r <= 1'b0;
			pos <= 32'sh0;
			n_org <= 8'h0;
		end else begin
			ab_r <= {qa, qb};
			org_r <= org;
			if (org && !org_r)
				n_org <= n_org + 8'h1;
			// A leading B counts up; a jump of both lines is a resync, not a count
			case ({ab_r, qa, qb})
				4'b0010, 4'b1011, 4'b1101, 4'b0100: pos <= pos + 32'sh1;
				4'b1000, 4'b1110, 4'b0111, 4'b0001: pos <= pos - 32'sh1;
				default: ;
			endcase
		end
	end
endmodule

`default_nettype wire

// >>> sim/edp_pulse_out_bench.sv
`timescale 1ns/1ps
`default_nettype none

module edp_pulse_out_bench;
	import edp_pkg::*;
	typedef struct {logic lin; logic rev; logic [31:0] pc; logic [31:0] lr; int n; logic up; logic [31:0] e;} edp_row_t;
	logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
	logic              enc_step, enc_up, enc_origin, quad_a_out, quad_a_out_n, quad_b_out, quad_b_out_n;
	logic              origin_out, origin_out_n;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd, p0;
	logic signed [31:0] pos;
	logic [7:0]        n_org;
	int                errors, n_compared;
	edp_row_t rows [6] = '{'{0, 0, 2, 20, 16, 1, 8}, '{0, 0, 4, 20, 16, 0, -16}, '{0, 1, 4, 20, 4, 1, -4},
		'{1, 0, 2, 5, 10, 1, 5}, '{1, 0, 2, 10, 7, 0, -7}, '{0, 0, 1, 20, 16, 1, 4}};

	edp_pulse_out dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .enc_step, .enc_up, .enc_origin, .quad_a_out, .quad_a_out_n, .quad_b_out, .quad_b_out_n,
		.origin_out, .origin_out_n);
	edp_host_model host_u (.pclk, .presetn, .qa(quad_a_out), .qb(quad_b_out), .org(origin_out), .pos, .n_org);

	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end

	// ****************
	// Tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic test_done;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			errors++;
			test_done;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task automatic cfg(input logic lin, input logic rev, input logic both, input logic [31:0] pc, lr);
		apb(1, A_ROT_DIR, {31'h0, rev});
		apb(1, A_ORIGIN_SEL, {31'h0, both});
		apb(1, A_PULSE_CNT, pc);
		apb(1, A_LIN_RES, lr);
		apb(1, A_ENC_RES, 32'h10);
		apb(1, A_PITCH_EDGES, 32'ha);
		apb(1, A_CTRL, {31'h0, lin});
		apb(1, A_CTRL, {30'h0, 1'b1, lin});
		repeat (2) @(posedge pclk);
	endtask

	task automatic step(input int n, input logic up);
		repeat (n) begin
			@(posedge pclk);
			enc_step <= 1;
			enc_up <= up;
		end
		@(posedge pclk);
		enc_step <= 0;
		repeat (2) @(posedge pclk);
	endtask

	// Mark crossing at one edge per count, then the pulse must last two edges
	task automatic org(input logic up, input logic exp);
		@(posedge pclk);
		enc_origin <= 1;
		enc_up <= up;
		@(posedge pclk);
		enc_origin <= 0;
		@(negedge pclk);
		chk("origin", {31'h0, exp}, {31'h0, origin_out});
		step(1, up);
		@(negedge pclk);
		chk("origin_hold", {31'h0, exp}, {31'h0, origin_out});
		step(2, up);
		@(negedge pclk);
		chk("origin_end", 32'h0, {31'h0, origin_out});
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		errors = 0;
		n_compared = 0;
		{presetn, ce, psel, penable, pwrite, enc_step, enc_up, enc_origin} = 8'h40;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		chk("reset_out", 32'h15, {26'h0, quad_a_out, quad_a_out_n, quad_b_out, quad_b_out_n, origin_out,
			origin_out_n});
		@(posedge pclk);
		presetn <= 1;
		rdc("origin_sel_rst", A_ORIGIN_SEL, {16'h0, RST_ORIGIN_SEL});
		rdc("pulse_cnt_rst", A_PULSE_CNT, RST_PULSE_CNT);
		rdc("lin_res_rst", A_LIN_RES, RST_LIN_RES);
		apb(0, 18'h00004, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		apb(1, A_ORIGIN_SEL, 32'h1);
		rdc("origin_sel_rw", A_ORIGIN_SEL, 32'h1);
		foreach (rows[k]) begin
			cfg(rows[k].lin, rows[k].rev, 1'b0, rows[k].pc, rows[k].lr);
			p0 = pos;
			step(rows[k].n, rows[k].up);
			chk("host_count", rows[k].e, pos - p0);
			rdc("position", A_POSITION, rows[k].e);
		end
		// Crossings are made in bursts of one or two counts on back-to-back cycles, slow for the host
		cfg(0, 0, 0, 32'h4, 32'ha);
		org(0, 0);
		org(1, 1);
		org(0, 0);
		cfg(1, 1, 0, 32'h4, 32'ha);
		org(0, 0);
		org(1, 1);
		org(0, 1);
		rdc("status", A_STATUS, 32'hb);
		cfg(0, 1, 1, 32'h4, 32'ha);
		org(1, 0);
		org(0, 1);
		org(1, 1);
		chk("origins", 32'h5, {24'h0, n_org});
		apb(0, A_POSITION, 32'h0);
		p0 = rd;
		@(posedge pclk);
		ce <= 0;
		step(2, 1);
		ce <= 1;
		rdc("frozen", A_POSITION, p0);
		test_done;
	end
endmodule

`default_nettype wire
